// [verilog/sleep_gate_pkg.sv]
// package: register map, field layout and mode encodings of the gating and reset block
package sleep_gate_pkg;

    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [11:0] OFF_SOFT_RESET_ZERO  = 12'h040;
    localparam logic [11:0] OFF_RUN_GATES        = 12'h108;
    localparam logic [11:0] OFF_SLEEP_GATES      = 12'h118;
    localparam logic [11:0] OFF_DEEP_GATES       = 12'h128;
    localparam logic [11:0] OFF_RUN_CLOCK_CFG    = 12'h060;
    localparam logic [11:0] OFF_CAPABILITIES_ONE = 12'h010;
    localparam logic [11:0] OFF_IRQ_STATUS       = 12'h800;
    localparam logic [11:0] OFF_IRQ_MASK         = 12'h804;
    localparam logic [11:0] OFF_FAULT_ADDR       = 12'h808;

    // ==========================================================
    // field layout
    localparam int          PORT_COUNT      = 5;
    localparam logic [31:0] PORT_GATE_MASK  = 32'h0000001F;
    localparam int          PWM_RESET_BIT   = 20;
    localparam int          ADC_RESET_BIT   = 16;
    localparam int          WDOG_RESET_BIT  = 3;
    localparam logic [31:0] SOFT_RESET_MASK = 32'h00110008;
    localparam int          ACG_BIT         = 27;
    localparam logic [31:0] RUN_CFG_MASK    = 32'h08000000;
    localparam logic [31:0] ZERO_WORD       = 32'h00000000;
    localparam logic [31:0] RESET_WORD      = 32'h00000000;

    // interrupt status bits
    localparam int IRQ_FAULT_BIT = 0;
    localparam int IRQ_MODE_BIT  = 1;
    localparam int IRQ_WIDTH     = 2;

    // ==========================================================
    // operating state of the system
    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_SLEEP,
        MODE_DEEP_SLEEP
    } power_mode_t;

endpackage : sleep_gate_pkg

// [verilog/deep_sleep_gating_and_soft_reset.sv]
// deep-sleep port clock gating, run/sleep gating select and software reset control
//
// Decided for this implementation: the plain strobed port.
module deep_sleep_gating_and_soft_reset
    import sleep_gate_pkg::*;
#(
    parameter int          PORTS    = PORT_COUNT,
    parameter logic [31:0] CAPS_ONE = 32'h00110008  // units present; value arbitrary
) (
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    // register port
    input  wire logic [11:0]          reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_write,
    input  wire logic                 reg_read,
    output logic      [31:0]          reg_rdata,
    // operating state from the power controller
    input  wire logic                 sleep_req,
    input  wire logic                 deep_sleep_req,
    // port accesses from the peripheral bus
    input  wire logic                 port_access,
    input  wire logic [PORTS-1:0]     port_select,
    output logic                      bus_fault,
    // clock enables and resets toward the units
    output logic      [PORTS-1:0]     port_clock_en,
    output logic                      pwm_reset,
    output logic                      adc_reset,
    output logic                      watchdog_reset,
    output logic                      irq
);

    // ==========================================================
    // register map, byte offsets from the control base
    //   0x010 capabilities one, read only, units fitted
    //   0x040 soft reset control zero
    //   0x060 run clock configuration, auto gating bit only
    //   0x108 run-mode port gates
    //   0x118 sleep-mode port gates
    //   0x128 deep-sleep port gates
    //   0x800 interrupt status, cleared by its read
    //   0x804 interrupt mask, same layout as status
    //   0x808 ports named by the last faulting access
    // unmapped offsets read zero and ignore writes
    //
    // field layout
    //   port gates: ports a to e on bits 0 to 4
    //   soft reset: modulator 20, converter 16, watchdog 3
    //   status: bit 0 bus fault, bit 1 operating state change
    //
    // timing seen at the ports
    //   a write lands at the edge that samples its strobe
    //   read data stand only in the cycle after the strobe
    //   clock enables follow a state request after two edges
    //   bus fault answers one cycle after the faulting access
    //   unit resets follow their register bits by one cycle
    //   irq follows the masked status by one cycle
    //
    // hazards
    //   enables are registered: a port stays clocked one cycle
    //   after its gate clears, and an access then completes
    //   a held reset bit keeps its unit in reset until cleared
    //   a status read and a new event in one cycle keep the event
    //   a unit absent from capabilities one never leaves reset low
    //   all inputs share this clock, so no synchronisers are fitted

    // ==========================================================
    // state
    logic [PORTS-1:0]     run_gates_reg;
    logic [PORTS-1:0]     sleep_gates_reg;
    logic [PORTS-1:0]     deep_gates_reg;
    logic [31:0]          soft_reset_reg;
    logic [31:0]          run_cfg_reg;
    logic [IRQ_WIDTH-1:0] irq_status_reg;
    logic [IRQ_WIDTH-1:0] irq_mask_reg;
    logic [PORTS-1:0]     fault_port_reg;
    power_mode_t          mode_reg;
    power_mode_t          mode_next;
    logic [PORTS-1:0]     gates_next;

    // ==========================================================
    // address decode
    wire logic wr_soft  = reg_write && (reg_addr == OFF_SOFT_RESET_ZERO);
    wire logic wr_run   = reg_write && (reg_addr == OFF_RUN_GATES);
    wire logic wr_sleep = reg_write && (reg_addr == OFF_SLEEP_GATES);
    wire logic wr_deep  = reg_write && (reg_addr == OFF_DEEP_GATES);
    wire logic wr_cfg   = reg_write && (reg_addr == OFF_RUN_CLOCK_CFG);
    wire logic wr_mask  = reg_write && (reg_addr == OFF_IRQ_MASK);
    wire logic rd_stat  = reg_read && (reg_addr == OFF_IRQ_STATUS);
    wire logic acg_on   = run_cfg_reg[ACG_BIT];

    // ==========================================================
    // operating state decode
    always_comb begin
        mode_next = MODE_RUN;
        if (deep_sleep_req) begin
            mode_next = MODE_DEEP_SLEEP;
        end else if (sleep_req) begin
            mode_next = MODE_SLEEP;
        end
    end

    // gate set per low-power state, run gates without auto gating
    // auto gating select
    wire logic [PORTS-1:0] sleep_pick = acg_on ? sleep_gates_reg : run_gates_reg;
    wire logic [PORTS-1:0] deep_pick  = acg_on ? deep_gates_reg : run_gates_reg;

    // pick the gate set for the mode
    always_comb begin
        // gating by state, only with auto gating
        case (mode_reg)
            MODE_RUN:        gates_next = run_gates_reg;
            MODE_SLEEP:      gates_next = sleep_pick;
            MODE_DEEP_SLEEP: gates_next = deep_pick;
            default:         gates_next = run_gates_reg;
        endcase
    end

    // fault when any selected port is unclocked
    // ports named by the access that have no clock now
    wire logic [PORTS-1:0] unclocked_sel = port_select & ~port_clock_en;
    wire logic fault_now = port_access && (unclocked_sel != '0);
    wire logic mode_evt  = (mode_next != mode_reg);

    // ==========================================================
    // read mux
    logic [31:0] rdata_next;
    always_comb begin
        rdata_next = ZERO_WORD;
        case (reg_addr)
            OFF_DEEP_GATES:       rdata_next = 32'(deep_gates_reg);
            OFF_RUN_GATES:        rdata_next = 32'(run_gates_reg);
            OFF_SLEEP_GATES:      rdata_next = 32'(sleep_gates_reg);
            OFF_SOFT_RESET_ZERO:  rdata_next = soft_reset_reg & SOFT_RESET_MASK;
            OFF_RUN_CLOCK_CFG:    rdata_next = run_cfg_reg;
            OFF_CAPABILITIES_ONE: rdata_next = CAPS_ONE;
            OFF_IRQ_STATUS:       rdata_next = 32'(irq_status_reg);
            OFF_IRQ_MASK:         rdata_next = 32'(irq_mask_reg);
            OFF_FAULT_ADDR:       rdata_next = 32'(fault_port_reg);
            default:              rdata_next = ZERO_WORD;
        endcase
    end

    // ==========================================================
    // gating registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            run_gates_reg   <= '0;
            sleep_gates_reg <= '0;
            deep_gates_reg  <= '0;
        end else begin
            if (wr_run) begin
                run_gates_reg <= reg_wdata[PORTS-1:0];
            end
            if (wr_sleep) begin
                sleep_gates_reg <= reg_wdata[PORTS-1:0];
            end
            if (wr_deep) begin
                deep_gates_reg <= reg_wdata[PORTS-1:0];
            end
        end
    end

    // ==========================================================
    // soft reset write mask
    // only documented bits of units listed in capabilities one move;
    // every other bit keeps its old value, which stays zero
    wire logic [31:0] soft_write_mask = CAPS_ONE & SOFT_RESET_MASK;
    wire logic [31:0] soft_reset_next = (reg_wdata & soft_write_mask)
                                      | (soft_reset_reg & ~soft_write_mask);

    // soft reset and run clock configuration
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            soft_reset_reg <= RESET_WORD;
            run_cfg_reg    <= RESET_WORD;
        end else begin
            if (wr_soft) begin
                soft_reset_reg <= soft_reset_next;
            end
            if (wr_cfg) begin
                run_cfg_reg <= reg_wdata & RUN_CFG_MASK;
            end
        end
    end

    // operating state and clock enables
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mode_reg      <= MODE_RUN;
            port_clock_en <= '0;
        end else begin
            mode_reg      <= mode_next;
            port_clock_en <= gates_next;
        end
    end

    // unit reset levels picked from the soft reset register
    wire logic pwm_reset_next      = soft_reset_reg[PWM_RESET_BIT];
    wire logic adc_reset_next      = soft_reset_reg[ADC_RESET_BIT];
    wire logic watchdog_reset_next = soft_reset_reg[WDOG_RESET_BIT];

    // unit resets driven from the soft reset bits
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pwm_reset      <= 1'b0;
            adc_reset      <= 1'b0;
            watchdog_reset <= 1'b0;
        end else begin
            pwm_reset      <= pwm_reset_next;
            adc_reset      <= adc_reset_next;
            watchdog_reset <= watchdog_reset_next;
        end
    end

    // ==========================================================
    // bus fault answer and fault capture
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bus_fault      <= 1'b0;
            fault_port_reg <= '0;
        end else begin
            bus_fault <= fault_now;
            if (fault_now) begin
                fault_port_reg <= port_select;
            end
        end
    end

    // ==========================================================
    // status events and next status, a new event beats a clearing read
    logic [IRQ_WIDTH-1:0] irq_events;
    logic [IRQ_WIDTH-1:0] irq_status_next;
    always_comb begin
        irq_events                = '0;
        irq_events[IRQ_FAULT_BIT] = fault_now;
        irq_events[IRQ_MODE_BIT]  = mode_evt;
        irq_status_next           = irq_events
                                  | (irq_status_reg & ~{IRQ_WIDTH{rd_stat}});
    end

    // interrupt status: set wins over read clear
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irq_status_reg <= '0;
            irq_mask_reg   <= '0;
            irq            <= 1'b0;
        end else begin
            irq_status_reg <= irq_status_next;
            if (wr_mask) begin
                irq_mask_reg <= reg_wdata[IRQ_WIDTH-1:0];
            end
            irq <= ((irq_status_reg & irq_mask_reg) != '0);
        end
    end

    // read data, valid the cycle after the strobe
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reg_rdata <= ZERO_WORD;
        end else if (reg_read) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= ZERO_WORD;
        end
    end

endmodule : deep_sleep_gating_and_soft_reset

// [test/gate_reset_chk.sv]
// checker: port-level assertions of the gating and reset block
module gate_reset_chk
    import sleep_gate_pkg::*;
#(
    parameter int          PORTS    = PORT_COUNT,
    parameter logic [31:0] CAPS_ONE = 32'h00110008
) (
    input wire logic             clock,
    input wire logic             rst_n,
    input wire logic [11:0]      reg_addr,
    input wire logic [31:0]      reg_wdata,
    input wire logic             reg_write,
    input wire logic             reg_read,
    input wire logic [31:0]      reg_rdata,
    input wire logic             port_access,
    input wire logic [PORTS-1:0] port_select,
    input wire logic             bus_fault,
    input wire logic [PORTS-1:0] port_clock_en,
    input wire logic             pwm_reset,
    input wire logic             adc_reset,
    input wire logic             watchdog_reset
);
    // ==========================================================
    // helpers
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // soft reset write and access to an unclocked port
    wire logic sr_wr = reg_write && reg_addr == OFF_SOFT_RESET_ZERO;
    wire logic miss  = port_access && |(port_select & ~port_clock_en);

    // ==========================================================
    // properties
    property p_fault; miss |=> bus_fault; endproperty
    a_fault: assert property (p_fault) else $error("fault missing");
    property p_nofault; !miss |=> !bus_fault; endproperty
    a_nofault: assert property (p_nofault) else $error("spurious fault");
    property p_boot; $rose(rst_n) |-> port_clock_en == '0 && !pwm_reset; endproperty
    a_boot: assert property (p_boot) else $error("outputs not clear after reset");
    property p_pwm; sr_wr |-> ##2 pwm_reset == ($past(reg_wdata[20], 2) & CAPS_ONE[20]); endproperty
    a_pwm: assert property (p_pwm) else $error("pwm reset wrong");
    property p_adc; sr_wr |-> ##2 adc_reset == ($past(reg_wdata[16], 2) & CAPS_ONE[16]); endproperty
    a_adc: assert property (p_adc) else $error("adc reset wrong");
    property p_wdog; sr_wr |-> ##2 watchdog_reset == ($past(reg_wdata[3], 2) & CAPS_ONE[3]); endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog reset wrong");
    property p_hold; !sr_wr |-> ##2 $stable({pwm_reset, adc_reset, watchdog_reset}); endproperty
    a_hold: assert property (p_hold) else $error("unit reset moved");
    property p_idle; !reg_read |=> reg_rdata == '0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside slot");
    property p_deep_hi; reg_read && reg_addr == OFF_DEEP_GATES |=> reg_rdata[31:5] == '0; endproperty
    a_deep_hi: assert property (p_deep_hi) else $error("gate upper bits set");
    property p_sr_ro;
        reg_read && reg_addr == OFF_SOFT_RESET_ZERO |=> (reg_rdata & ~(SOFT_RESET_MASK & CAPS_ONE)) == '0;
    endproperty
    a_sr_ro: assert property (p_sr_ro) else $error("soft reset stray bits");
endmodule : gate_reset_chk

bind deep_sleep_gating_and_soft_reset gate_reset_chk #(.PORTS(PORTS), .CAPS_ONE(CAPS_ONE)) i_chk (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .port_access(port_access), .port_select(port_select), .bus_fault(bus_fault),
    .port_clock_en(port_clock_en), .pwm_reset(pwm_reset), .adc_reset(adc_reset),
    .watchdog_reset(watchdog_reset));

// [test/test_deep_sleep_gating_and_soft_reset.sv]
// testbench: registers, modes and port accesses against a bench model
module test_deep_sleep_gating_and_soft_reset
    import sleep_gate_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] CAPS = 32'h00010008;  // pwm absent to exercise masking
    logic clock, rst_n, reg_write, reg_read, sleep_req, deep_sleep_req, port_access;
    logic bus_fault, pwm_reset, adc_reset, watchdog_reset, irq;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, s, run_g, slp_g, dp_g, auto_clock_gating_select, sr, st, fp;
    logic [4:0]  port_select, port_clock_en;
    power_mode_t md;
    int          fail_count, tests_run, cycles;

    deep_sleep_gating_and_soft_reset #(.CAPS_ONE(CAPS)) i_dut (
        .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req), .port_access(port_access),
        .port_select(port_select), .bus_fault(bus_fault), .port_clock_en(port_clock_en),
        .pwm_reset(pwm_reset), .adc_reset(adc_reset), .watchdog_reset(watchdog_reset), .irq(irq));

    // ==========================================================
    // clock, timeout and helpers
    always #5 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    function automatic logic [4:0] en_exp();
        if (!auto_clock_gating_select[27] || md == MODE_RUN) return run_g[4:0];
        if (md == MODE_SLEEP) return slp_g[4:0];
        return dp_g[4:0];
    endfunction : en_exp
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    // bus cycles: one-cycle strobes, read data in the following cycle
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_write <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge clock);
        reg_read <= 1'b1; reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 chk("reg_rdata", e, reg_rdata);
    endtask : rd
    // operating state change, then the selected gate set must apply
    task automatic mode(input logic sq, input logic dq);
        power_mode_t n;
        n = dq ? MODE_DEEP_SLEEP : (sq ? MODE_SLEEP : MODE_RUN);
        if (n != md) st[1] = 1'b1;
        md = n;
        @(posedge clock);
        sleep_req <= sq; deep_sleep_req <= dq;
        repeat (3) @(posedge clock);
        #1 chk("port_clock_en", {27'h0, en_exp()}, {27'h0, port_clock_en});
    endtask : mode
    // one port access, faulting when a selected port is unclocked
    task automatic access(input logic [4:0] sel);
        logic f;
        f = |(sel & ~en_exp());
        if (f) begin st[0] = 1'b1; fp = {27'h0, sel}; end
        @(posedge clock);
        port_access <= 1'b1; port_select <= sel;
        @(posedge clock);
        port_access <= 1'b0;
        #1 chk("bus_fault", {31'h0, f}, {31'h0, bus_fault});
    endtask : access

    // ==========================================================
    // main sequence
    initial begin
        {clock, rst_n, reg_write, reg_read, sleep_req, deep_sleep_req, port_access} = '0;
        reg_addr = '0; reg_wdata = '0; port_select = '0;
        {run_g, slp_g, dp_g, auto_clock_gating_select, sr, st, fp} = '0;
        md = MODE_RUN;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rd(OFF_DEEP_GATES, 32'h0);
        rd(OFF_SOFT_RESET_ZERO, 32'h0);
        rd(12'h300, 32'h0);
        chk("port_clock_en", 32'h0, {27'h0, port_clock_en});
        s = 32'h0da11e99;
        for (int i = 0; i < 6; i++) begin
            s = lfsr(s);
            wr(OFF_DEEP_GATES, s);
            dp_g = s & PORT_GATE_MASK;
            rd(OFF_DEEP_GATES, dp_g);
            wr(OFF_DEEP_GATES, dp_g);
            s = lfsr(s);
            wr(OFF_SOFT_RESET_ZERO, i == 4 ? 32'hFFFFFFFF : (i == 5 ? 32'h0 : s));
            sr = (i == 4 ? 32'hFFFFFFFF : (i == 5 ? 32'h0 : s)) & SOFT_RESET_MASK & CAPS;
            wr(12'h300, s);
            rd(OFF_SOFT_RESET_ZERO, sr);
            chk("unit_resets", sr, {11'h0, pwm_reset, 3'h0, adc_reset, 12'h0,
                watchdog_reset, 3'h0});
        end
        for (int a = 0; a < 2; a++) begin
            wr(OFF_RUN_CLOCK_CFG, a ? 32'hFFFFFFFF : 32'h0);
            auto_clock_gating_select = a ? RUN_CFG_MASK : 32'h0;
            rd(OFF_RUN_CLOCK_CFG, auto_clock_gating_select);
            s = lfsr(s); wr(OFF_RUN_GATES, s); run_g = s & PORT_GATE_MASK;
            s = lfsr(s); wr(OFF_SLEEP_GATES, s); slp_g = s & PORT_GATE_MASK;
            s = lfsr(s); wr(OFF_DEEP_GATES, s); dp_g = s & PORT_GATE_MASK;
            for (int m = 0; m < 4; m++) begin
                mode(m == 1 || m == 3, m >= 2);
                for (int p = 0; p < 5; p++) access(5'h01 << p);
            end
            mode(1'b0, 1'b0);
        end
        rd(OFF_FAULT_ADDR, fp);
        rd(OFF_IRQ_STATUS, st);
        st = '0;
        wr(OFF_IRQ_MASK, 32'h1);
        wr(OFF_RUN_GATES, 32'h0);
        run_g = '0;
        access(5'h10);
        @(posedge clock);
        #1 chk("irq", 32'h1, {31'h0, irq});
        rd(OFF_IRQ_STATUS, st);
        st = '0;
        @(posedge clock);
        #1 chk("irq", 32'h0, {31'h0, irq});
        wr(OFF_IRQ_MASK, 32'h0);
        access(5'h01);
        repeat (2) @(posedge clock);
        #1 chk("irq", 32'h0, {31'h0, irq});
        rd(OFF_IRQ_MASK, 32'h0);
        tally_and_finish();
    end
endmodule : test_deep_sleep_gating_and_soft_reset
